// >>> hdl/pgsr_top.sv
// top of the peripheral gate and soft reset slice, an apb slave
// assumes: apb master on ref_clk; port_access pulses mark accesses to each port
//
// Our own choice: register access over APB.
module pgsr_top (
    input wire logic ref_clk, // system clock, 20 MHz
    input wire logic reset, // sync reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [pgsr_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [31:0] capability_mask_1, // module-present bits
    input wire logic sleep_mode, // processor in sleep
    input wire logic deep_sleep_mode, // processor in deep sleep
    input wire logic [pgsr_pkg::NUM_PORTS-1:0] port_access, // access pulse per port
    output logic [pgsr_pkg::NUM_PORTS-1:0] port_clk_en, // clock enable per port
    output logic [pgsr_pkg::NUM_PORTS-1:0] port_bus_fault, // fault pulse per port
    output logic pwm_reset_ctl, // pwm module reset
    output logic adc0_reset_ctl, // adc 0 reset
    output logic hibernation_reset_ctl, // hibernation module reset
    output logic watchdog_reset_ctl, // watchdog reset
    output logic irq // level interrupt
);
    import pgsr_pkg::*;

    // bus phases of the slave, gray along idle -> setup -> answer
    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_SETUP = 2'b01,
        APB_ANSWER = 2'b11
    } pgsr_apb_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] run_port_clock_gate_ff;
    logic [7:0] sleep_port_clock_gate_ff;
    logic [7:0] deep_sleep_port_clock_gate_ff;
    logic [31:0] peripheral_soft_reset_0_ff;
    logic auto_clock_gating_enable_ff;
    logic [7:0] irq_status_ff;
    logic [7:0] irq_mask_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    pgsr_apb_state_t apb_state_ff;

    logic [7:0] nxt_run_port_clock_gate;
    logic [7:0] nxt_sleep_port_clock_gate;
    logic [7:0] nxt_deep_sleep_port_clock_gate;
    logic [31:0] nxt_peripheral_soft_reset_0;
    logic nxt_auto_clock_gating_enable;
    logic [7:0] nxt_irq_status;
    logic [7:0] nxt_irq_mask;
    logic nxt_irq;
    logic [31:0] nxt_prdata;
    logic nxt_pready;
    logic nxt_pslverr;
    pgsr_apb_state_t nxt_apb_state;

    logic access;
    logic done;
    logic wr_done;
    logic rd_done;
    logic hit;
    logic [31:0] rd_val;
    logic [7:0] eff_gate;

    pgsr_ctl_if ctl ();

    ////////////////////////////////////////////////////////////////////////////
    // address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_val = RST_VAL_ZERO;
        case (paddr)
            OFF_SOFT_RESET_0: begin
                rd_val = peripheral_soft_reset_0_ff & SR_IMPL_MASK;
            end
            OFF_RUN_CLK_CFG: begin
                rd_val[CFG_AUTO_GATE_BIT] = auto_clock_gating_enable_ff;
            end
            OFF_RUN_GATE: begin
                rd_val[7:0] = run_port_clock_gate_ff;
            end
            OFF_SLEEP_GATE: begin
                rd_val[7:0] = sleep_port_clock_gate_ff;
            end
            OFF_DS_GATE: begin
                // upper bits stay zero from the default
                rd_val[7:0] = deep_sleep_port_clock_gate_ff;
            end
            OFF_IRQ_STATUS: begin
                rd_val[7:0] = irq_status_ff;
            end
            OFF_IRQ_MASK: begin
                rd_val[7:0] = irq_mask_ff;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, answer registered so outputs come from flops
    // only an access that followed its setup cycle is answered, so a stray
    // penable without setup never completes a transfer
    always_comb begin
        access = psel & penable;
        done = access & pready_ff;
        wr_done = done & pwrite & hit;
        rd_done = done & ~pwrite & hit;
        nxt_apb_state = apb_state_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = RST_VAL_ZERO;
        case (apb_state_ff)
            APB_IDLE: begin
                if (psel & ~penable) begin
                    nxt_apb_state = APB_SETUP;
                end
            end
            APB_SETUP: begin
                if (access) begin
                    nxt_apb_state = APB_ANSWER;
                    nxt_pready = 1'b1;
                    nxt_pslverr = ~hit;
                    if (~pwrite) begin
                        nxt_prdata = rd_val;
                    end
                end else if (~psel) begin
                    nxt_apb_state = APB_IDLE;
                end
            end
            APB_ANSWER: begin
                // completion edge; a back-to-back setup is seen on the next edge
                nxt_apb_state = APB_IDLE;
            end
            default: begin
                nxt_apb_state = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            apb_state_ff <= APB_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= RST_VAL_ZERO;
        end else begin
            apb_state_ff <= nxt_apb_state;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_comb begin
        nxt_run_port_clock_gate = run_port_clock_gate_ff;
        nxt_sleep_port_clock_gate = sleep_port_clock_gate_ff;
        nxt_deep_sleep_port_clock_gate = deep_sleep_port_clock_gate_ff;
        nxt_peripheral_soft_reset_0 = peripheral_soft_reset_0_ff;
        nxt_auto_clock_gating_enable = auto_clock_gating_enable_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_done) begin
            case (paddr)
                OFF_SOFT_RESET_0: begin
                    // bits of absent modules keep their old value
                    nxt_peripheral_soft_reset_0 =
                        ((pwdata & capability_mask_1) |
                         (peripheral_soft_reset_0_ff & ~capability_mask_1))
                        & SR_IMPL_MASK;
                end
                OFF_RUN_CLK_CFG: begin
                    nxt_auto_clock_gating_enable = pwdata[CFG_AUTO_GATE_BIT];
                end
                OFF_RUN_GATE: begin
                    nxt_run_port_clock_gate = pwdata[7:0];
                end
                OFF_SLEEP_GATE: begin
                    nxt_sleep_port_clock_gate = pwdata[7:0];
                end
                OFF_DS_GATE: begin
                    nxt_deep_sleep_port_clock_gate = pwdata[7:0];
                end
                OFF_IRQ_MASK: begin
                    nxt_irq_mask = pwdata[7:0];
                end
                default: begin
                    nxt_irq_mask = irq_mask_ff;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_port_clock_gate_ff <= GATE_RST_VAL;
            sleep_port_clock_gate_ff <= GATE_RST_VAL;
            deep_sleep_port_clock_gate_ff <= GATE_RST_VAL;
            peripheral_soft_reset_0_ff <= RST_VAL_ZERO;
            auto_clock_gating_enable_ff <= 1'b0;
            irq_mask_ff <= GATE_RST_VAL;
        end else begin
            run_port_clock_gate_ff <= nxt_run_port_clock_gate;
            sleep_port_clock_gate_ff <= nxt_sleep_port_clock_gate;
            deep_sleep_port_clock_gate_ff <= nxt_deep_sleep_port_clock_gate;
            peripheral_soft_reset_0_ff <= nxt_peripheral_soft_reset_0;
            auto_clock_gating_enable_ff <= nxt_auto_clock_gating_enable;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gate set selection by power mode
    always_comb begin
        // without auto gating the run set rules in every mode
        eff_gate = run_port_clock_gate_ff;
        if (auto_clock_gating_enable_ff) begin
            if (deep_sleep_mode) begin
                eff_gate = deep_sleep_port_clock_gate_ff;
            end else if (sleep_mode) begin
                eff_gate = sleep_port_clock_gate_ff;
            end
        end
    end

    assign ctl.gate_en = eff_gate;
    assign ctl.port_sel = port_access;
    assign ctl.soft_rst[RST_IDX_WDOG] = peripheral_soft_reset_0_ff[SR_WDOG_BIT];
    assign ctl.soft_rst[RST_IDX_HIBN] = peripheral_soft_reset_0_ff[SR_HIBN_BIT];
    assign ctl.soft_rst[RST_IDX_ADC0] = peripheral_soft_reset_0_ff[SR_ADC0_BIT];
    assign ctl.soft_rst[RST_IDX_PWM] = peripheral_soft_reset_0_ff[SR_PWM_BIT];

    pgsr_port_gate #(
        .PORTS(NUM_PORTS)
    ) i_pgsr_port_gate (
        .ref_clk(ref_clk),
        .reset(reset),
        .bus(ctl.gate)
    );

    pgsr_mod_reset #(
        .LINES(NUM_RST)
    ) i_pgsr_mod_reset (
        .ref_clk(ref_clk),
        .reset(reset),
        .bus(ctl.rst)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus fault interrupt: sticky, cleared by reading the status register
    always_comb begin
        nxt_irq_status = irq_status_ff;
        if (rd_done && paddr == OFF_IRQ_STATUS) begin
            // only bits that were returned are cleared
            nxt_irq_status = irq_status_ff & ~prdata_ff[7:0];
        end
        // a fault in the clearing cycle still sets its bit
        nxt_irq_status = nxt_irq_status | ctl.fault;
        nxt_irq = |(irq_status_ff & irq_mask_ff);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_status_ff <= GATE_RST_VAL;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_ff <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port_clk_en = ctl.clk_en;
    assign port_bus_fault = ctl.fault;
    assign watchdog_reset_ctl = ctl.mod_rst[RST_IDX_WDOG];
    assign hibernation_reset_ctl = ctl.mod_rst[RST_IDX_HIBN];
    assign adc0_reset_ctl = ctl.mod_rst[RST_IDX_ADC0];
    assign pwm_reset_ctl = ctl.mod_rst[RST_IDX_PWM];
    assign irq = irq_ff;
endmodule

// >>> hdl/pgsr_pkg.sv
// package: offsets, field positions and reset values of the gate/reset slice
// assumes: a 12-bit byte address window of the system control block
package pgsr_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned NUM_PORTS = 8;
    localparam int unsigned NUM_RST = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFF_SOFT_RESET_0 = 12'h040;
    localparam logic [11:0] OFF_RUN_CLK_CFG = 12'h060;
    localparam logic [11:0] OFF_RUN_GATE = 12'h100;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h118;
    localparam logic [11:0] OFF_DS_GATE = 12'h128;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h150;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h154;

    ////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int unsigned SR_PWM_BIT = 20;
    localparam int unsigned SR_ADC0_BIT = 16;
    localparam int unsigned SR_HIBN_BIT = 6;
    localparam int unsigned SR_WDOG_BIT = 3;
    localparam logic [31:0] SR_IMPL_MASK = 32'h0011_0048;
    localparam logic [31:0] GATE_IMPL_MASK = 32'h0000_00ff;
    localparam int unsigned CFG_AUTO_GATE_BIT = 0;
    localparam logic [31:0] CFG_IMPL_MASK = 32'h0000_0001;
    localparam logic [31:0] IRQ_IMPL_MASK = 32'h0000_00ff;

    // index of each module reset line
    localparam int unsigned RST_IDX_WDOG = 0;
    localparam int unsigned RST_IDX_HIBN = 1;
    localparam int unsigned RST_IDX_ADC0 = 2;
    localparam int unsigned RST_IDX_PWM = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] RST_VAL_ZERO = 32'h0000_0000;
    localparam logic [7:0] GATE_RST_VAL = 8'h00;
    localparam logic [3:0] SRST_RST_VAL = 4'h0;
endpackage

// >>> hdl/pgsr_ctl_if.sv
// interface: gate enables, port accesses and reset lines between the slice's modules
// assumes: one clock, everything launched and sampled on ref_clk
interface pgsr_ctl_if;
    logic [7:0] gate_en;
    logic [7:0] port_sel;
    logic [7:0] clk_en;
    logic [7:0] fault;
    logic [3:0] soft_rst;
    logic [3:0] mod_rst;

    modport ctl (output gate_en, output port_sel, output soft_rst,
                 input clk_en, input fault, input mod_rst);
    modport gate (input gate_en, input port_sel, output clk_en, output fault);
    modport rst (input soft_rst, output mod_rst);
endinterface

// >>> hdl/pgsr_port_gate.sv
// port clock gating: one registered clock enable and bus-fault flag per port
// assumes: gate_en and port_sel are synchronous to ref_clk
module pgsr_port_gate #(
    parameter int unsigned PORTS = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic reset, // sync reset, active high
    pgsr_ctl_if.gate bus // enables in, clock enables and faults out
);
    import pgsr_pkg::*;

    logic [PORTS-1:0] clk_en_ff;
    logic [PORTS-1:0] fault_ff;
    logic [PORTS-1:0] nxt_clk_en;
    logic [PORTS-1:0] nxt_fault;

    for (genvar g = 0; g < PORTS; g++) begin : g_port
        // enable only moves on a clock edge, so a unit never sees a cut pulse
        always_comb begin
            nxt_clk_en[g] = bus.gate_en[g];
            nxt_fault[g] = bus.port_sel[g] & ~clk_en_ff[g];
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                clk_en_ff[g] <= GATE_RST_VAL[g];
                fault_ff[g] <= 1'b0;
            end else begin
                clk_en_ff[g] <= nxt_clk_en[g];
                fault_ff[g] <= nxt_fault[g];
            end
        end
    end

    assign bus.clk_en = clk_en_ff;
    assign bus.fault = fault_ff;
endmodule

// >>> hdl/pgsr_mod_reset.sv
// module reset drivers: hold each module in reset while its control bit is one
// assumes: soft_rst comes from the register file on the same clock
module pgsr_mod_reset #(
    parameter int unsigned LINES = 4
) (
    input wire logic ref_clk, // system clock
    input wire logic reset, // sync reset, active high
    pgsr_ctl_if.rst bus // control bits in, module resets out
);
    import pgsr_pkg::*;

    logic [LINES-1:0] mod_rst_ff;
    logic [LINES-1:0] nxt_mod_rst;

    always_comb begin
        nxt_mod_rst = bus.soft_rst;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mod_rst_ff <= SRST_RST_VAL;
        end else begin
            mod_rst_ff <= nxt_mod_rst;
        end
    end

    assign bus.mod_rst = mod_rst_ff;
endmodule

// >>> tb/pgsr_top_sva.sv
// checker: register, fault and reset-line relations at the slice's top ports
// assumes: bound to pgsr_top, one clock, synchronous active-high reset
module pgsr_top_sva (
    input wire logic ref_clk, // system clock
    input wire logic reset, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [pgsr_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic [31:0] capability_mask_1, // module present
    input wire logic [7:0] port_access, // access pulses
    input wire logic [7:0] port_clk_en, // port enables
    input wire logic [7:0] port_bus_fault, // fault pulses
    input wire logic pwm_reset_ctl, // pwm reset
    input wire logic adc0_reset_ctl, // adc reset
    input wire logic hibernation_reset_ctl, // hibernation reset
    input wire logic watchdog_reset_ctl // watchdog reset
);
    timeunit 1ns;
    timeprecision 1ps;
    import pgsr_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic wr_sr;
    logic wr_pwm_open;
    logic rd_end;
    // completion edge only: a write lands here and nowhere else
    assign wr_sr = psel && penable && pready && pwrite && paddr == OFF_SOFT_RESET_0;
    assign wr_pwm_open = wr_sr && capability_mask_1[SR_PWM_BIT];
    assign rd_end = psel && penable && pready && !pwrite;
    ////////////////////////////////////////
    gated_fault_a: assert property (1'h1 |=>
        port_bus_fault == ($past(port_access) & ~$past(port_clk_en)))
        else $error("fault pulse does not match gated accesses");
    ds_reserved_a: assert property (rd_end && paddr == OFF_DS_GATE |->
        prdata[31:8] == 24'h0) else $error("gate register upper bits not zero");
    sr_reserved_a: assert property (rd_end && paddr == OFF_SOFT_RESET_0 |->
        (prdata & ~SR_IMPL_MASK) == 32'h0) else $error("soft reset unused bits set");
    pwm_set_a: assert property ($rose(pwm_reset_ctl) |->
        $past(wr_pwm_open, 2)) else $error("pwm reset rose unasked");
    adc_set_a: assert property ($rose(adc0_reset_ctl) |->
        $past(wr_sr, 2)) else $error("adc reset rose unasked");
    hibernate_set_a: assert property ($rose(hibernation_reset_ctl) |->
        $past(wr_sr, 2)) else $error("hibernation reset rose unasked");
    watchdog_set_a: assert property ($rose(watchdog_reset_ctl) |->
        $past(wr_sr, 2)) else $error("watchdog reset rose unasked");
    watchdog_release_a: assert property ($fell(watchdog_reset_ctl) |->
        $past(wr_sr, 2)) else $error("watchdog reset fell unasked");
    pwm_masked_a: assert property (wr_sr && !capability_mask_1[SR_PWM_BIT] |->
        ##2 $stable(pwm_reset_ctl)) else $error("masked pwm bit changed");
endmodule

bind pgsr_top pgsr_top_sva i_pgsr_top_sva (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .capability_mask_1(capability_mask_1), .port_access(port_access),
    .port_clk_en(port_clk_en), .port_bus_fault(port_bus_fault),
    .pwm_reset_ctl(pwm_reset_ctl), .adc0_reset_ctl(adc0_reset_ctl),
    .hibernation_reset_ctl(hibernation_reset_ctl), .watchdog_reset_ctl(watchdog_reset_ctl));

// >>> tb/pgsr_bench.sv
// bench: apb register tests, gate-set selection, faults, interrupt, soft resets
// assumes: pgsr_top with its checker bound; bench is the only apb master
module pgsr_bench
    import pgsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] capability_mask_1 = 32'hffff_ffff;
    logic sleep_mode = 1'h0;
    logic deep_sleep_mode = 1'h0;
    logic [7:0] port_access = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [7:0] port_clk_en, port_bus_fault;
    logic pwm_reset_ctl, adc0_reset_ctl, hibernation_reset_ctl, watchdog_reset_ctl;
    logic [3:0] lines;
    logic [31:0] rd_val;
    logic rd_err;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int sr_bit [4] = '{SR_PWM_BIT, SR_ADC0_BIT, SR_HIBN_BIT, SR_WDOG_BIT};

    assign lines = {pwm_reset_ctl, adc0_reset_ctl, hibernation_reset_ctl, watchdog_reset_ctl};
    always #25 ref_clk = ~ref_clk;

    pgsr_top i_pgsr_top (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capability_mask_1(capability_mask_1), .sleep_mode(sleep_mode),
        .deep_sleep_mode(deep_sleep_mode), .port_access(port_access),
        .port_clk_en(port_clk_en), .port_bus_fault(port_bus_fault),
        .pwm_reset_ctl(pwm_reset_ctl), .adc0_reset_ctl(adc0_reset_ctl),
        .hibernation_reset_ctl(hibernation_reset_ctl),
        .watchdog_reset_ctl(watchdog_reset_ctl), .irq(irq));

    ////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until the edge that sees pready; data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1) @(posedge ref_clk);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'h0, a, 32'h0);
        chk(name, exp, rd_val);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // one-cycle access pulse, fault pulse looked at in the following cycle
    task automatic poke(input logic [7:0] v, input logic [7:0] exp);
        @(posedge ref_clk);
        port_access <= v;
        @(posedge ref_clk);
        port_access <= 8'h00;
        @(negedge ref_clk);
        chk("bus_fault", {24'h0, exp}, {24'h0, port_bus_fault});
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'h0;
        rd(OFF_SOFT_RESET_0, 32'h0, "soft_reset");
        rd(OFF_DS_GATE, 32'h0, "ds_gate");
        chk("clk_en", 32'h0, {24'h0, port_clk_en});
        rd(12'hffc, 32'h0, "unmapped");
        chk("unmapped_err", 32'h1, {31'h0, rd_err});
        $display("test reset_values done");
        apb(1'h1, OFF_DS_GATE, 32'hffff_ff5a);
        rd(OFF_DS_GATE, 32'h0000_005a, "ds_gate");
        apb(1'h1, OFF_RUN_GATE, 32'h0000_0081);
        apb(1'h1, OFF_SLEEP_GATE, 32'h0000_0024);
        apb(1'h1, OFF_IRQ_MASK, 32'h0000_0002);
        deep_sleep_mode <= 1'h1;
        settle(2);
        chk("auto_off", 32'h81, {24'h0, port_clk_en});
        apb(1'h1, OFF_RUN_CLK_CFG, 32'h1);
        settle(2);
        chk("deep_set", 32'h5a, {24'h0, port_clk_en});
        @(posedge ref_clk);
        sleep_mode <= 1'h1;
        settle(2);
        chk("deep_wins", 32'h5a, {24'h0, port_clk_en});
        @(posedge ref_clk);
        deep_sleep_mode <= 1'h0;
        settle(2);
        chk("sleep_set", 32'h24, {24'h0, port_clk_en});
        $display("test gate_sets done");
        poke(8'h81, 8'h81);
        settle(3);
        chk("irq_masked", 32'h0, {31'h0, irq});
        poke(8'h26, 8'h02);
        settle(3);
        chk("irq_raised", 32'h1, {31'h0, irq});
        rd(OFF_IRQ_STATUS, 32'h83, "irq_status");
        settle(2);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        rd(OFF_IRQ_STATUS, 32'h0, "irq_status");
        sleep_mode <= 1'h0;
        settle(2);
        chk("run_auto", 32'h81, {24'h0, port_clk_en});
        $display("test faults done");
        apb(1'h1, OFF_SOFT_RESET_0, 32'hffff_ffff);
        rd(OFF_SOFT_RESET_0, 32'h0011_0048, "soft_reset");
        chk("reset_lines", 32'hf, {28'h0, lines});
        capability_mask_1 <= 32'hffef_ffff;
        apb(1'h1, OFF_SOFT_RESET_0, 32'h0);
        rd(OFF_SOFT_RESET_0, 32'h0010_0000, "soft_reset_masked");
        chk("reset_lines", 32'h8, {28'h0, lines});
        capability_mask_1 <= 32'hffff_ffff;
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, OFF_SOFT_RESET_0, 32'h1 << sr_bit[i]);
            rd(OFF_SOFT_RESET_0, 32'h1 << sr_bit[i], "soft_reset_bit");
            chk("reset_line", 32'h1 << (3 - i), {28'h0, lines});
        end
        apb(1'h1, OFF_SOFT_RESET_0, 32'h0);
        settle(2);
        chk("reset_released", 32'h0, {28'h0, lines});
        $display("test soft_reset done");
        results();
    end
endmodule
